// ---- rtl/psr_sense_id_regs.sv ----
// Purpose: Read-only sense, power-up mode and identification registers.
// Assumes: The serial control port front end presents register index,
//   read and write strobes on ref_clk_in; sense inputs are asynchronous.
// Notes: Read data appears one cycle after the read strobe.
`timescale 1ns/1ns

module psr_sense_id_regs #(
  parameter logic [4:0] REVISION = 5'h00,   // Arbitrary value.
  parameter logic [2:0] GENERATION = 3'h2,  // Arbitrary value.
  parameter logic [1:0] FIN_VERSION = 2'h0, // Arbitrary value.
  parameter logic [1:0] FAB_ID = 2'h0,      // Arbitrary value.
  parameter logic [5:0] GEN_CODE = 6'h05    // Arbitrary value.
) (
  input wire logic ref_clk_in,                // 10 MHz register clock.
  input wire logic rstn_in,                   // Synchronous reset, active low.
  input wire logic [psr_pkg::ADDR_W-1:0] reg_addr_in, // Register index.
  input wire logic reg_rd_in,                 // Read strobe, one cycle.
  input wire logic reg_wr_in,                 // Write strobe, one cycle.
  input wire logic [psr_pkg::DATA_W-1:0] reg_wdata_in, // Write data.
  output logic [psr_pkg::DATA_W-1:0] reg_rdata_out, // Read data.
  output logic reg_rvalid_out,                // Read data valid pulse.
  input wire logic button_three_level_in,     // Button three pin level.
  input wire logic button_one_level_in,       // Button one pin level.
  input wire logic button_two_level_in,       // Button two pin level.
  input wire logic usb_lowpower_boot_level_in, // Low-power USB boot level.
  input wire logic thermal_low_warn_level_in, // Low thermal warning level.
  input wire logic thermal_high_warn_level_in, // High thermal warning level.
  input wire logic clock_source_level_in,     // Clock source level.
  input wire logic battery_removed_level_in,  // Battery-detect level.
  input wire logic mode_pin_decode_lo_in,     // Mode pin decode, low bit.
  input wire logic mode_pin_decode_hi_in,     // Mode pin decode, high bit.
  input wire logic [1:0] powerup_select_first_in, // First select pin state.
  input wire logic [1:0] powerup_select_second_in, // Second select pin state.
  input wire logic charger_serial_single_in,  // Raw serial/single sense.
  input wire logic charger_enabled_in,        // Charger enable level.
  input wire logic wall_charger_detect_level_in // Wall charger level.
);

  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  localparam int N_SYNC = 17;

  logic [N_SYNC-1:0] raw_vec;
  logic [N_SYNC-1:0] sync_vec;
  logic s_btn3;
  logic s_btn1;
  logic s_btn2;
  logic s_lpb;
  logic s_thl;
  logic s_thh;
  logic s_clk;
  logic s_batt;
  logic s_mode_lo;
  logic s_mode_hi;
  logic [1:0] s_sel_first;
  logic [1:0] s_sel_second;
  logic s_chg_ss;
  logic s_chg_en;
  logic s_wall;

  // Gathers every pin level into one bundle for the synchroniser.
  assign raw_vec = {wall_charger_detect_level_in, charger_enabled_in,
                    charger_serial_single_in, powerup_select_second_in,
                    powerup_select_first_in, mode_pin_decode_hi_in,
                    mode_pin_decode_lo_in, battery_removed_level_in,
                    clock_source_level_in, thermal_high_warn_level_in,
                    thermal_low_warn_level_in, usb_lowpower_boot_level_in,
                    button_two_level_in, button_one_level_in,
                    button_three_level_in};

  psr_sync2 #(
    .WIDTH(N_SYNC)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .async_in(raw_vec),
    .sync_out(sync_vec)
  );

  // Splits the synchronised bundle back into named levels.
  assign {s_wall, s_chg_en, s_chg_ss, s_sel_second, s_sel_first, s_mode_hi,
          s_mode_lo, s_batt, s_clk, s_thh, s_thl, s_lpb, s_btn2, s_btn1,
          s_btn3} = sync_vec;

  // ---------------------------------------------------------------
  // Sense word assembly
  // ---------------------------------------------------------------

  // Places the eight event sense levels at their register positions.
  function automatic logic [23:0] event_word(input logic b3, input logic b1,
                                             input logic b2, input logic lp,
                                             input logic tl, input logic th,
                                             input logic ck, input logic bt);
    logic [23:0] w;
    w = psr_pkg::RST_ZERO_WORD;
    w[psr_pkg::BIT_BUTTON_THREE] = b3;
    w[psr_pkg::BIT_BUTTON_ONE] = b1;
    w[psr_pkg::BIT_BUTTON_TWO] = b2;
    w[psr_pkg::BIT_USB_LP_BOOT] = lp;
    w[psr_pkg::BIT_THERM_LOW] = tl;
    w[psr_pkg::BIT_THERM_HIGH] = th;
    w[psr_pkg::BIT_CLK_SOURCE] = ck;
    w[psr_pkg::BIT_BATT_REMOVED] = bt;
    return w;
  endfunction : event_word

  logic [23:0] sense_word;
  logic [23:0] event_mask;

  // Live sense levels; no reset acts on them.
  assign sense_word = event_word(s_btn3, s_btn1, s_btn2, s_lpb, s_thl, s_thh,
                                 s_clk, s_batt);
  assign event_mask = event_word(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);

  // ---------------------------------------------------------------
  // Start-up latching of pin states
  // ---------------------------------------------------------------
  psr_pkg::psr_start_e start_reg;
  psr_pkg::psr_start_e start_next;
  logic [1:0] settle_reg;
  logic [1:0] settle_next;
  logic [1:0] sel_first_reg;
  logic [1:0] sel_first_next;
  logic [1:0] sel_second_reg;
  logic [1:0] sel_second_next;
  logic chg_ss_reg;
  logic chg_ss_next;

  // Waits for the synchroniser to fill, then captures the select pins once.
  always_comb begin
    start_next = start_reg;
    settle_next = settle_reg;
    sel_first_next = sel_first_reg;
    sel_second_next = sel_second_reg;
    chg_ss_next = chg_ss_reg;
    unique case (start_reg)
      psr_pkg::PSR_SETTLE: begin
        settle_next = settle_reg + 2'h1;
        if (settle_reg == psr_pkg::STARTUP_SETTLE) begin
          start_next = psr_pkg::PSR_CAPTURE;
        end
      end
      psr_pkg::PSR_CAPTURE: begin
        sel_first_next = s_sel_first;
        sel_second_next = s_sel_second;
        chg_ss_next = s_chg_ss;
        start_next = psr_pkg::PSR_RUN;
      end
      psr_pkg::PSR_RUN: begin
        if (s_chg_en) begin
          chg_ss_next = s_chg_ss;
        end
      end
    endcase
  end

  // Registers the start-up state and the latched pin states.
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      start_reg <= psr_pkg::PSR_SETTLE;
      settle_reg <= 2'h0;
      sel_first_reg <= 2'h0;
      sel_second_reg <= 2'h0;
      chg_ss_reg <= 1'b0;
    end else begin
      start_reg <= start_next;
      settle_reg <= settle_next;
      sel_first_reg <= sel_first_next;
      sel_second_reg <= sel_second_next;
      chg_ss_reg <= chg_ss_next;
    end
  end

  // ---------------------------------------------------------------
  // Fixed and assembled read words
  // ---------------------------------------------------------------
  logic [23:0] mode_word;
  logic [23:0] ident_word;

  // Power-up mode word from live decode, latched pins and charger bits.
  always_comb begin
    mode_word = psr_pkg::RST_ZERO_WORD;
    mode_word[psr_pkg::BIT_MODE_DEC_LO] = s_mode_lo;
    mode_word[psr_pkg::BIT_MODE_DEC_HI] = s_mode_hi;
    mode_word[psr_pkg::POS_SELECT_FIRST +: 2] = sel_first_reg;
    mode_word[psr_pkg::POS_SELECT_SECOND +: 2] = sel_second_reg;
    mode_word[psr_pkg::BIT_CHG_SER_SINGLE] = chg_ss_reg;
    mode_word[psr_pkg::BIT_WALL_CHG] = s_wall;
  end

  // Identification word; unlisted bits stay zero.
  always_comb begin
    ident_word = psr_pkg::RST_ZERO_WORD;
    ident_word[psr_pkg::POS_REVISION +: 5] = REVISION;
    ident_word[psr_pkg::POS_GENERATION +: 3] = GENERATION;
    ident_word[psr_pkg::POS_FIN +: 2] = FIN_VERSION;
    ident_word[psr_pkg::POS_FAB +: 2] = FAB_ID;
    ident_word[psr_pkg::POS_GEN_CODE +: 6] = GEN_CODE;
  end

  // ---------------------------------------------------------------
  // Event status flags
  // ---------------------------------------------------------------
  logic [23:0] prev_sense_reg;
  logic [23:0] prev_sense_next;
  logic [23:0] status_reg;
  logic [23:0] status_next;
  logic [23:0] status_set;
  logic [23:0] status_clr;

  // In PSR_RUN, a change of any sense level sets its flag; writing one clears it,
  // but a change in the same cycle wins over the clear.
  always_comb begin
    prev_sense_next = sense_word;
    status_set = psr_pkg::RST_ZERO_WORD;
    if (start_reg == psr_pkg::PSR_RUN) begin
      status_set = (sense_word ^ prev_sense_reg) & event_mask;
    end
    status_clr = psr_pkg::RST_ZERO_WORD;
    if (reg_wr_in && (reg_addr_in == psr_pkg::IDX_EVENT_STATUS)) begin
      status_clr = reg_wdata_in & event_mask;
    end
    status_next = (status_reg & ~status_clr) | status_set;
  end

  // Registers the flags and the previous sense levels.
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      status_reg <= psr_pkg::RST_ZERO_WORD;
    end else begin
      status_reg <= status_next;
    end
    prev_sense_reg <= prev_sense_next;
  end

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  logic [23:0] rdata_reg;
  logic [23:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  // Selects the read word; writes other than flag clears are ignored.
  always_comb begin
    rvalid_next = reg_rd_in;
    rdata_next = rdata_reg;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        psr_pkg::IDX_EVENT_STATUS: rdata_next = status_reg;
        psr_pkg::IDX_EVENT_SENSE: rdata_next = sense_word;
        psr_pkg::IDX_POWERUP_MODE: rdata_next = mode_word;
        psr_pkg::IDX_IDENT: rdata_next = ident_word;
        psr_pkg::IDX_UNUSED_EIGHT: rdata_next = psr_pkg::RST_ZERO_WORD;
        default: rdata_next = psr_pkg::RST_ZERO_WORD;
      endcase
    end
  end

  // Registers the read answer.
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      rdata_reg <= psr_pkg::RST_ZERO_WORD;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign reg_rvalid_out = rvalid_reg;

endmodule : psr_sense_id_regs

// ---- pkg/psr_pkg.sv ----
// Purpose: Constants for the sense and identification register group.
// Assumes: 24-bit registers addressed by a 6-bit register index.
// Notes: Identity field values are parameters of the top module.
package psr_pkg;

  // ---------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;
  localparam logic [5:0] IDX_EVENT_STATUS = 6'h03;
  localparam logic [5:0] IDX_EVENT_SENSE = 6'h05;
  localparam logic [5:0] IDX_POWERUP_MODE = 6'h06;
  localparam logic [5:0] IDX_IDENT = 6'h07;
  localparam logic [5:0] IDX_UNUSED_EIGHT = 6'h08;

  // ---------------------------------------------------------------
  // Event sense and event status bit positions
  // ---------------------------------------------------------------
  localparam int BIT_BUTTON_THREE = 2;
  localparam int BIT_BUTTON_ONE = 3;
  localparam int BIT_BUTTON_TWO = 4;
  localparam int BIT_USB_LP_BOOT = 11;
  localparam int BIT_THERM_LOW = 12;
  localparam int BIT_THERM_HIGH = 13;
  localparam int BIT_CLK_SOURCE = 14;
  localparam int BIT_BATT_REMOVED = 22;

  // ---------------------------------------------------------------
  // Power-up mode register bit positions
  // ---------------------------------------------------------------
  localparam int BIT_MODE_DEC_LO = 0;
  localparam int BIT_MODE_DEC_HI = 1;
  localparam int POS_SELECT_FIRST = 2;
  localparam int POS_SELECT_SECOND = 4;
  localparam int BIT_CHG_SER_SINGLE = 9;
  localparam int BIT_WALL_CHG = 10;

  // ---------------------------------------------------------------
  // Identification register field positions
  // ---------------------------------------------------------------
  localparam int POS_REVISION = 0;
  localparam int POS_GENERATION = 6;
  localparam int POS_FIN = 9;
  localparam int POS_FAB = 11;
  localparam int POS_GEN_CODE = 13;

  // ---------------------------------------------------------------
  // Reset values and timing counts
  // ---------------------------------------------------------------
  localparam logic [23:0] RST_ZERO_WORD = 24'h000000;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] STARTUP_SETTLE = 2'h2;

  // Start-up sequencing of the latched pin states.
  typedef enum logic [1:0] {
    PSR_SETTLE,
    PSR_CAPTURE,
    PSR_RUN
  } psr_start_e;

endpackage : psr_pkg

// ---- rtl/psr_sync2.sv ----
// Purpose: Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes: Each bit is an independent level; no bus coherency is needed.
// Notes: Carries no reset so that sense levels are unaffected by resets.
`timescale 1ns/1ns
module psr_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_in,           // Register clock.
  input wire logic [WIDTH-1:0] async_in, // Asynchronous levels.
  output logic [WIDTH-1:0] sync_out      // Synchronised levels.
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] stable_reg;
  logic [WIDTH-1:0] stable_next;

  // First stage is read only by the second stage.
  always_comb begin
    meta_next = async_in;
    stable_next = meta_reg;
  end

  // Both stages run free of any reset.
  always_ff @(posedge ref_clk_in) begin
    meta_reg <= meta_next;
    stable_reg <= stable_next;
  end

  assign sync_out = stable_reg;

endmodule : psr_sync2

// ---- sim/psr_sense_id_regs_asserts.sv ----
// Purpose: Checker for the sense, mode and identification registers.
// Assumes: Read data and valid appear one cycle after the read strobe.
// Notes: Sense levels pass two synchroniser flops before a read sees them.
`timescale 1ns/1ns
module psr_sense_id_regs_asserts #(
  parameter logic [4:0] REVISION = 5'h00,
  parameter logic [2:0] GENERATION = 3'h2,
  parameter logic [1:0] FIN_VERSION = 2'h0,
  parameter logic [1:0] FAB_ID = 2'h0,
  parameter logic [5:0] GEN_CODE = 6'h05
) (
  input wire logic ref_clk_in, // Register clock.
  input wire logic rstn_in, // Reset, active low.
  input wire logic [psr_pkg::ADDR_W-1:0] reg_addr_in, // Index.
  input wire logic reg_rd_in, // Read strobe.
  input wire logic reg_wr_in, // Write strobe.
  input wire logic [psr_pkg::DATA_W-1:0] reg_wdata_in, // Write data.
  input wire logic [psr_pkg::DATA_W-1:0] reg_rdata_out, // Read data.
  input wire logic reg_rvalid_out, // Read valid.
  input wire logic button_three_level_in, // Button three.
  input wire logic button_one_level_in, // Button one.
  input wire logic button_two_level_in, // Button two.
  input wire logic usb_lowpower_boot_level_in, // USB boot.
  input wire logic thermal_low_warn_level_in, // Thermal low.
  input wire logic thermal_high_warn_level_in, // Thermal high.
  input wire logic clock_source_level_in, // Clock source.
  input wire logic battery_removed_level_in, // Battery removed.
  input wire logic mode_pin_decode_lo_in, // Mode decode low.
  input wire logic mode_pin_decode_hi_in, // Mode decode high.
  input wire logic [1:0] powerup_select_first_in, // First select.
  input wire logic [1:0] powerup_select_second_in, // Second select.
  input wire logic charger_serial_single_in, // Serial/single.
  input wire logic charger_enabled_in, // Charger enable.
  input wire logic wall_charger_detect_level_in // Wall charger.
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  logic rd_sense;
  logic rd_mode;
  logic rd_ident;
  logic rd_eight;
  logic rd_stat;
  // Decodes which register a read strobe selects.
  assign rd_sense = reg_rd_in && (reg_addr_in == psr_pkg::IDX_EVENT_SENSE);
  assign rd_mode = reg_rd_in && (reg_addr_in == psr_pkg::IDX_POWERUP_MODE);
  assign rd_ident = reg_rd_in && (reg_addr_in == psr_pkg::IDX_IDENT);
  assign rd_eight = reg_rd_in && (reg_addr_in == psr_pkg::IDX_UNUSED_EIGHT);
  assign rd_stat = reg_rd_in && (reg_addr_in == psr_pkg::IDX_EVENT_STATUS);
  a_read_answered: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");
  a_no_stray_valid: assert property (!reg_rd_in |=> !reg_rvalid_out)
    else $error("valid without a read");
  a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved without a read");
  a_sense_word: assert property (rd_sense |=> reg_rdata_out == {1'b0,
    $past(battery_removed_level_in, 3), 7'h00, $past({clock_source_level_in,
    thermal_high_warn_level_in, thermal_low_warn_level_in, usb_lowpower_boot_level_in}, 3),
    6'h00, $past({button_two_level_in, button_one_level_in, button_three_level_in}, 3), 2'h0})
    else $error("sense word wrong");
  a_mode_live_bits: assert property (rd_mode |=> reg_rdata_out[23:11] == 13'h0000 &&
    reg_rdata_out[8:6] == 3'h0 && reg_rdata_out[10] == $past(wall_charger_detect_level_in, 3)
    && reg_rdata_out[1:0] == $past({mode_pin_decode_hi_in, mode_pin_decode_lo_in}, 3))
    else $error("mode word wrong");
  a_ident_word: assert property (rd_ident |=> reg_rdata_out ==
    {5'h00, GEN_CODE, FAB_ID, FIN_VERSION, GENERATION, 1'b0, REVISION})
    else $error("identification word wrong");
  a_eight_zero: assert property (rd_eight |=> reg_rdata_out == 24'h000000)
    else $error("unused register not zero");
  a_status_spare: assert property (rd_stat |=> (reg_rdata_out & 24'hBF87E3) == 24'h000000)
    else $error("status bit outside the sense set");
  c_sense_seen: cover property (rd_sense ##1 reg_rdata_out != 24'h000000);
  c_mode_read: cover property (rd_mode);
  c_event_flag: cover property (rd_stat ##1 reg_rdata_out != 24'h000000);
endmodule : psr_sense_id_regs_asserts

bind psr_sense_id_regs psr_sense_id_regs_asserts #(.REVISION(REVISION),
  .GENERATION(GENERATION), .FIN_VERSION(FIN_VERSION), .FAB_ID(FAB_ID),
  .GEN_CODE(GEN_CODE)) i_psr_sense_id_regs_asserts (.ref_clk_in, .rstn_in,
  .reg_addr_in, .reg_rd_in, .reg_wr_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out,
  .button_three_level_in, .button_one_level_in, .button_two_level_in,
  .usb_lowpower_boot_level_in, .thermal_low_warn_level_in, .thermal_high_warn_level_in,
  .clock_source_level_in, .battery_removed_level_in, .mode_pin_decode_lo_in,
  .mode_pin_decode_hi_in, .powerup_select_first_in, .powerup_select_second_in,
  .charger_serial_single_in, .charger_enabled_in, .wall_charger_detect_level_in);

// ---- sim/psr_host_model.sv ----
// Purpose: Host side of the register port, issuing reads and writes.
// Assumes: A request is taken at the edge after it is driven.
// Notes: Released lines carry the inverse of their last value.
`timescale 1ns/1ns
module psr_host_model (
  input wire logic ref_clk_in, // Register clock.
  input wire logic [psr_pkg::DATA_W-1:0] reg_rdata_in, // Read data.
  input wire logic reg_rvalid_in, // Read valid.
  output logic [psr_pkg::ADDR_W-1:0] reg_addr_out, // Register index.
  output logic reg_rd_out, // Read strobe.
  output logic reg_wr_out, // Write strobe.
  output logic [psr_pkg::DATA_W-1:0] reg_wdata_out // Write data.
);
  // Idle bus at time zero.
  initial begin
    reg_addr_out = 6'h00;
    reg_rd_out = 1'b0;
    reg_wr_out = 1'b0;
    reg_wdata_out = 24'h000000;
  end

  // One read; a missing answer returns unknown data so the compare fails.
  task automatic read(input logic [5:0] addr, output logic [23:0] data);
    @(posedge ref_clk_in);
    reg_addr_out <= addr;
    reg_rd_out <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~addr;
    @(posedge ref_clk_in);
    data = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 24'hXXXXXX;
  endtask : read

  // One write of a whole word.
  task automatic write(input logic [5:0] addr, input logic [23:0] data);
    @(posedge ref_clk_in);
    reg_addr_out <= addr;
    reg_wdata_out <= data;
    reg_wr_out <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~addr;
    reg_wdata_out <= ~data;
  endtask : write
endmodule : psr_host_model

// ---- sim/tb_psr_sense_id_regs.sv ----
// Purpose: Self-checking bench for the sense and identification registers.
// Assumes: Host model issues accesses; the bench drives the sense pins.
// Notes: Identity parameters are set to arbitrary values.
`timescale 1ns/1ns
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_psr_sense_id_regs;
  localparam logic [23:0] ID_EXP = 24'h054D55;
  logic clk = 1'b0;
  logic rstn, rd, wr, ser, chen, wall, mlo, mhi, rvalid;
  logic [5:0] addr;
  logic [23:0] wdata, rdata, d;
  logic [1:0] sel1, sel2;
  logic [7:0] sns;
  int bad_count = 0;
  int n_tests = 0;
  int pos[8] = '{2, 3, 4, 11, 12, 13, 14, 22};
  always #50 clk = ~clk;
  // Identity values below are arbitrary.
  psr_sense_id_regs #(.REVISION(5'h15), .GENERATION(3'h5), .FIN_VERSION(2'h2),
    .FAB_ID(2'h1), .GEN_CODE(6'h2A)) i_psr_sense_id_regs (.ref_clk_in(clk),
    .rstn_in(rstn), .reg_addr_in(addr), .reg_rd_in(rd), .reg_wr_in(wr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .button_three_level_in(sns[0]), .button_one_level_in(sns[1]),
    .button_two_level_in(sns[2]), .usb_lowpower_boot_level_in(sns[3]),
    .thermal_low_warn_level_in(sns[4]), .thermal_high_warn_level_in(sns[5]),
    .clock_source_level_in(sns[6]), .battery_removed_level_in(sns[7]),
    .mode_pin_decode_lo_in(mlo), .mode_pin_decode_hi_in(mhi),
    .powerup_select_first_in(sel1), .powerup_select_second_in(sel2),
    .charger_serial_single_in(ser), .charger_enabled_in(chen),
    .wall_charger_detect_level_in(wall));
  psr_host_model i_psr_host_model (.ref_clk_in(clk), .reg_rdata_in(rdata),
    .reg_rvalid_in(rvalid), .reg_addr_out(addr), .reg_rd_out(rd), .reg_wr_out(wr),
    .reg_wdata_out(wdata));

  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // Waits a number of clock edges.
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // Holds reset for 20 edges, then waits for start-up to finish.
  task automatic do_reset;
    @(posedge clk);
    rstn <= 1'b0;
    wt(20);
    rstn <= 1'b1;
    wt(8);
  endtask : do_reset

  // Cuts a hang short well beyond the expected run length.
  initial begin
    wt(3000);
    bad_count++;
    complete_run();
  end

  // Main sequence of tests.
  initial begin
    rstn = 1'b0;
    sns = 8'h00;
    mlo = 1'b1;
    mhi = 1'b0;
    sel1 = 2'h1;
    sel2 = 2'h2;
    ser = 1'b1;
    chen = 1'b0;
    wall = 1'b1;
    do_reset();
    i_psr_host_model.read(psr_pkg::IDX_IDENT, d);
    `CHK(d, ID_EXP)
    i_psr_host_model.write(psr_pkg::IDX_IDENT, 24'hFFFFFF);
    i_psr_host_model.write(psr_pkg::IDX_UNUSED_EIGHT, 24'hFFFFFF);
    i_psr_host_model.read(psr_pkg::IDX_UNUSED_EIGHT, d);
    `CHK(d, 24'h000000)
    i_psr_host_model.read(psr_pkg::IDX_IDENT, d);
    `CHK(d, ID_EXP)
    $display("test ident done");
    i_psr_host_model.read(psr_pkg::IDX_POWERUP_MODE, d);
    `CHK(d, 24'h000625)
    @(posedge clk);
    sel1 <= 2'h3;
    sel2 <= 2'h0;
    ser <= 1'b0;
    wall <= 1'b0;
    mlo <= 1'b0;
    mhi <= 1'b1;
    wt(4);
    i_psr_host_model.read(psr_pkg::IDX_POWERUP_MODE, d);
    `CHK(d, 24'h000226)
    chen <= 1'b1;
    wt(4);
    i_psr_host_model.read(psr_pkg::IDX_POWERUP_MODE, d);
    `CHK(d, 24'h000026)
    chen <= 1'b0;
    wt(4);
    ser <= 1'b1;
    wt(4);
    i_psr_host_model.read(psr_pkg::IDX_POWERUP_MODE, d);
    `CHK(d, 24'h000026)
    $display("test mode done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      sns <= 8'h01 << i;
      wt(4);
      i_psr_host_model.read(psr_pkg::IDX_EVENT_SENSE, d);
      `CHK(d, 24'h000001 << pos[i])
    end
    @(posedge clk);
    sns <= 8'h87;
    do_reset();
    i_psr_host_model.read(psr_pkg::IDX_EVENT_SENSE, d);
    `CHK(d, 24'h40001C)
    $display("test sense done");
    i_psr_host_model.read(psr_pkg::IDX_EVENT_STATUS, d);
    `CHK(d, 24'h000000)
    @(posedge clk);
    sns <= 8'h07;
    wt(4);
    i_psr_host_model.read(psr_pkg::IDX_EVENT_STATUS, d);
    `CHK(d, 24'h400000)
    i_psr_host_model.write(psr_pkg::IDX_EVENT_STATUS, 24'h400000);
    i_psr_host_model.read(psr_pkg::IDX_EVENT_STATUS, d);
    `CHK(d, 24'h000000)
    $display("test status done");
    complete_run();
  end
endmodule : tb_psr_sense_id_regs
